// ==== src/adc_ctl_defines.vh ====
`ifndef ADC_CTL_DEFINES_VH
`define ADC_CTL_DEFINES_VH

// APB register byte offsets
`define OFS_CFG        12'h000
`define OFS_STATUS     12'h004
`define OFS_LAST_WORD  12'h008
// Configuration register fields
`define CFG_EN_BIT     0
`define CFG_RST        32'h0000_0001
// Control word field positions
`define CW_WRITE       11
`define CW_SEQ_HI      10
`define CW_CHAN_HI     7
`define CW_CHAN_LO     6
`define CW_PM_HI       5
`define CW_PM_LO       4
`define CW_SEQ_LO      3
`define CW_RANGE       1
`define CW_CODING      0
// Control word reset: normal power, channel 0, sequencer off
`define CW_RST         11'h030
// Power mode encodings
`define PM_NORMAL      2'b11
`define PM_FULL_SD     2'b10
`define PM_AUTO_SD     2'b01
// Serial frame layout
`define FRAME_BITS     5'd16
`define CW_BITS        5'd12
`define SAR_FIRST      5'd3
`define SAR_LAST       5'd14
// Conversion time: 16 serial clocks, 800 ns at 20 MHz
`define CONV_NS        800
`define CONV_SCLK_MHZ  20
`define CONV_SCLKS     ((`CONV_NS * `CONV_SCLK_MHZ) / 1000)

`endif

// ==== src/adc_power_and_sequencer_control.v ====
// Operation
// RL1: Power bits 11 keep the converter fully powered regardless of inputs.
// RL2: Power bits 10 power everything down but keep the control word.
// RL3: Full shutdown lasts until a later write changes the power bits.
// RL4: Power bits 01 shut down after each conversion that updated the control word.
// RL5: Host waits one microsecond of wake-up before a valid auto-shutdown conversion.
// RL6: Host never writes power bits 00.
// RL7: Sequence bit high 0 disables sequencer; channel comes from previous write.
// RL8: Sequence bits 10 keep a running sequence while other fields change.
// RL9: Sequence bits 11 convert channels 0 up to the selected final channel.
// RL10: Host leaves sequencing by writing with write bit 1, sequence bits 00.
// RL11: A running sequence advances one channel per chip-select falling edge.
// RL12: Serial clock shifts data and clocks the successive approximation.
// RL13: Conversion lasts a fixed count of serial clocks, 800 ns at 20 MHz.
// RL14: Control bit 1 selects the input span, reference or twice reference.
// RL15: Each conversion yields a 12-bit successive approximation result.
// RL16: After the final channel the sequence wraps to channel 0 indefinitely.
// RL17: Leading write bit gates loading of the other eleven control bits.
// RL18: Power bits sit at control word positions 5 and 4.
// RL19: Output word is two zeros, two channel bits, then 12 result bits.
// RL20: A write ending a sequence makes the next conversion follow it.
`include "adc_ctl_defines.vh"

module adc_power_and_sequencer_control #(
  parameter RES_BITS = 12
) (
  input  wire                ref_clk,
  input  wire                rst_b,
  // APB slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output wire                pready,
  output wire                pslverr,
  output reg  [31:0]         prdata,
  // Serial port pins
  input  wire                sclk,
  input  wire                cs_b,
  input  wire                din,
  output reg                 dout,
  output reg                 dout_oe,
  // Analog front-end control
  input  wire                comp_in,
  output reg  [RES_BITS-1:0] dac_code,
  output reg                 hold,
  output reg  [1:0]          mux_sel,
  output wire                range_ref,
  output wire                power_down
);

  // Reset release through two flip-flops
  reg rst_m_q;
  reg rst_s_q;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  wire rst_n = rst_s_q;

  // Pin synchroniser outputs; a level moves once stages two and three agree
  // Serial clock and chip-select idle high, so their filtered levels start high to avoid a false edge
  wire sclk_agree;
  wire sclk_late;
  wire sclk_lvl;
  wire cs_agree;
  wire cs_late;
  wire cs_lvl;
  wire din_lvl;
  wire cmp_lvl;

  // Serial clock pin
  in_sync3 #(
    .IDLE (1'b1)
  ) sclk_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (sclk),
    .agree   (sclk_agree),
    .late    (sclk_late),
    .level   (sclk_lvl)
  );

  // Chip-select pin
  in_sync3 #(
    .IDLE (1'b1)
  ) cs_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (cs_b),
    .agree   (cs_agree),
    .late    (cs_late),
    .level   (cs_lvl)
  );

  // Serial data in pin
  in_sync3 din_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (din),
    .agree   (),
    .late    (),
    .level   (din_lvl)
  );

  // Comparator result from the analog side
  in_sync3 cmp_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (comp_in),
    .agree   (),
    .late    (),
    .level   (cmp_lvl)
  );

  // Edge events from the filtered levels
  wire sclk_fall  = sclk_agree & sclk_lvl & ~sclk_late;
  wire cs_fall    = cs_agree & cs_lvl & ~cs_late;
  wire cs_rise    = cs_agree & ~cs_lvl & cs_late;

  // APB registers
  reg  [31:0] cfg_q;
  reg  [15:0] last_word_q;
  wire        apb_acc = psel & penable;
  wire        hit_cfg = (paddr == `OFS_CFG);
  wire        hit_sts = (paddr == `OFS_STATUS);
  wire        hit_lw  = (paddr == `OFS_LAST_WORD);
  wire        port_en = cfg_q[`CFG_EN_BIT];
  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~(hit_cfg | hit_sts | hit_lw);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `CFG_RST;
    end else if (apb_acc && pwrite && hit_cfg) begin
      cfg_q <= {31'h0000_0000, pwdata[`CFG_EN_BIT]};
    end
  end

  // Converter state
  reg [10:0]         ctrl_q;
  reg [11:0]         shift_q;
  reg [4:0]          cnt_q;
  reg                busy_q;
  reg [1:0]          cur_chan_q;
  reg [1:0]          last_chan_q;
  reg                seq_on_q;
  reg                auto_sd_q;
  reg [RES_BITS-1:0] res_q;
  reg [15:0]         word_q;

  wire [1:0] pm      = ctrl_q[`CW_PM_HI:`CW_PM_LO];   // RL18
  wire [1:0] cw_chan = ctrl_q[`CW_CHAN_HI:`CW_CHAN_LO];
  wire       coding  = ctrl_q[`CW_CODING];

  // Power state, one-hot; full shutdown holds until the power bits change
  // The invalid setting 00 is treated as powered so the part never sticks off
  localparam [3:0] PWR_ON    = 4'b0001;
  localparam [3:0] PWR_OFF   = 4'b0010;
  localparam [3:0] PWR_AWAKE = 4'b0100;
  localparam [3:0] PWR_SLEEP = 4'b1000;
  reg [3:0] pwr_q;
  reg [3:0] pwr_d;

  // Next power state from the stored power bits
  always @* begin
    case (pm)
      `PM_NORMAL:  pwr_d = PWR_ON;                                 // RL1
      `PM_FULL_SD: pwr_d = PWR_OFF;                                // RL2 RL3
      `PM_AUTO_SD: pwr_d = auto_sd_q ? PWR_SLEEP : PWR_AWAKE;      // RL4
      default:     pwr_d = PWR_ON;
    endcase
  end

  // Power state register
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_ON;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Circuitry is off in full shutdown and while auto shutdown sleeps
  assign power_down = pwr_q[1] | pwr_q[3];                     // RL2 RL4
  assign range_ref  = ctrl_q[`CW_RANGE];                      // RL14

  // Frame-end decode of the incoming control word
  wire [11:0] nw       = shift_q;
  wire        wr       = nw[`CW_WRITE];                        // RL17
  wire [1:0]  nw_seq   = {nw[`CW_SEQ_HI], nw[`CW_SEQ_LO]};
  wire [1:0]  nw_chan  = nw[`CW_CHAN_HI:`CW_CHAN_LO];
  wire        sar_step = (cnt_q >= `SAR_FIRST) && (cnt_q <= `SAR_LAST);
  // Bit under trial; only meaningful while sar_step is high
  wire [4:0]  sar_gap  = `SAR_LAST - cnt_q;
  wire [3:0]  sar_idx  = sar_gap[3:0];

  // Next decided bit and next trial value of the approximation register
  reg [RES_BITS-1:0] res_nx;
  reg [RES_BITS-1:0] dac_nx;
  reg                out_bit;
  // Guarded so that no index ever falls outside the result width
  always @* begin
    res_nx  = res_q;
    dac_nx  = res_q;
    out_bit = cmp_lvl;
    if (sar_step) begin
      res_nx[sar_idx] = cmp_lvl;                               // RL15
      dac_nx = res_nx;
      if (sar_idx != 4'h0) dac_nx[sar_idx - 4'h1] = 1'b1;
      if (sar_idx == 4'hb) out_bit = cmp_lvl ^ ~coding;        // Twos complement MSB
    end
  end

  // Channel chosen for the next conversion
  reg [1:0] nx_chan;
  reg       nx_seq;
  reg [1:0] nx_last;
  always @* begin
    nx_seq  = seq_on_q;
    nx_last = last_chan_q;
    nx_chan = cw_chan;
    if (wr && nw_seq == 2'b11) begin
      nx_seq  = 1'b1;                                          // RL9
      nx_last = nw_chan;
      nx_chan = 2'b00;
    end else if (wr && nw_seq != 2'b10) begin
      nx_seq  = 1'b0;                                          // RL20
      nx_chan = nw_chan;                                       // RL7
    end else if (seq_on_q) begin
      nx_chan = (cur_chan_q == last_chan_q) ? 2'b00 :          // RL16
                cur_chan_q + 2'b01;                            // RL11
    end else if (wr) begin
      nx_chan = nw_chan;                                       // RL8
    end
  end

  // Serial frame: chip-select fall samples, each serial clock fall steps
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= `CW_RST;
      shift_q     <= 12'h000;
      cnt_q       <= 5'd0;
      busy_q      <= 1'b0;
      cur_chan_q  <= 2'b00;
      last_chan_q <= 2'b00;
      seq_on_q    <= 1'b0;
      auto_sd_q   <= 1'b0;
      res_q       <= {RES_BITS{1'b0}};
      word_q      <= 16'h0000;
      last_word_q <= 16'h0000;
      dout        <= 1'b0;
      dout_oe     <= 1'b0;
      dac_code    <= {RES_BITS{1'b0}};
      hold        <= 1'b0;
      mux_sel     <= 2'b00;
    end else if (cs_rise) begin
      busy_q  <= 1'b0;
      hold    <= 1'b0;
      dout_oe <= 1'b0;
    end else if (cs_fall && port_en) begin
      busy_q    <= 1'b1;
      cnt_q     <= 5'd0;
      hold      <= 1'b1;
      dout_oe   <= 1'b1;
      dout      <= 1'b0;                                       // RL19
      auto_sd_q <= 1'b0;
      res_q     <= {RES_BITS{1'b0}};
      dac_code  <= {1'b1, {(RES_BITS-1){1'b0}}};
      cur_chan_q <= mux_sel;
      word_q    <= {2'b00, mux_sel, {RES_BITS{1'b0}}};
    end else if (busy_q && sclk_fall && cnt_q < `FRAME_BITS) begin
      cnt_q <= cnt_q + 5'd1;                                   // RL12
      if (cnt_q < `CW_BITS) shift_q <= {shift_q[10:0], din_lvl};
      if (cnt_q == 5'd0) dout <= 1'b0;
      if (cnt_q == 5'd1) dout <= cur_chan_q[1];
      if (cnt_q == 5'd2) dout <= cur_chan_q[0];
      if (sar_step) begin
        res_q    <= res_nx;
        dac_code <= dac_nx;
        dout     <= out_bit;
        word_q[sar_idx] <= out_bit;
      end
      if (cnt_q == `FRAME_BITS - 5'd1) begin
        // Conversion complete after the fixed serial clock count
        hold        <= 1'b0;                                   // RL13
        last_word_q <= word_q;
        seq_on_q    <= nx_seq;
        last_chan_q <= nx_last;
        mux_sel     <= nx_chan;
        if (wr) begin
          ctrl_q    <= nw[10:0];                               // RL17
          auto_sd_q <= (nw[`CW_PM_HI:`CW_PM_LO] == `PM_AUTO_SD); // RL4
        end
      end
    end
  end

  // APB read data
  always @* begin
    prdata = 32'h0000_0000;
    if (hit_cfg) prdata = cfg_q;
    // Status: sequencer, power, busy, current and next channel, control word
    if (hit_sts) prdata = {14'h0, seq_on_q, power_down, busy_q,
                           cur_chan_q, mux_sel, ctrl_q};
    if (hit_lw) prdata = {16'h0000, last_word_q};
  end

endmodule // adc_power_and_sequencer_control

// Three flip-flops on a pin; the level follows once stages two and three agree
// A one-cycle glitch therefore never reaches the level
module in_sync3 #(
  parameter [0:0] IDLE = 1'b0
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire pin,
  output wire agree,
  output wire late,
  output reg  level
);

  reg [2:0] stage_q;

  // Shift the pin in and move the level when two stages match
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= {3{IDLE}};
      level   <= IDLE;
    end else begin
      stage_q <= {stage_q[1:0], pin};
      if (agree) level <= stage_q[2];
    end
  end

  // Agreement of the last two stages and the last stage itself
  assign agree = (stage_q[1] == stage_q[2]);
  assign late  = stage_q[2];

endmodule // in_sync3

// ==== bench/adc_ctl_monitor.sv ====
module adc_ctl_monitor #(
  parameter RES_BITS = 12
) (
  input wire logic                ref_clk,
  input wire logic                rst_b,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [11:0]         paddr,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                sclk,
  input wire logic                cs_b,
  input wire logic                dout,
  input wire logic                dout_oe,
  input wire logic [RES_BITS-1:0] dac_code,
  input wire logic                hold,
  input wire logic [1:0]          mux_sel,
  input wire logic                range_ref
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] falls_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Link clock falls counted while the sample is held
  always @(posedge ref_clk) begin
    if ($rose(hold)) falls_q <= {4'h0, $fell(sclk)};
    else if ($fell(sclk)) falls_q <= falls_q + 5'd1;
  end
  sequence frame_open;
    $fell(cs_b) ##[1:6] $rose(dout_oe);
  endsequence
  sequence lead_zeros;
    !dout [*4];
  endsequence
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (psel && penable &&
                                (paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008)
                                |-> !pslverr)
    else $error("error on mapped address");
  lead_zero_a: assert property (frame_open |-> lead_zeros)
    else $error("output word does not start with zeros");
  oe_drop_a: assert property ($rose(cs_b) |-> ##[1:6] !dout_oe)
    else $error("data out still driven after frame");
  hold_len_a: assert property ($fell(hold) |-> falls_q == 5'd16)
    else $error("conversion not sixteen link clocks long");
  first_trial_a: assert property ($rose(hold) |-> ##[0:1] dac_code == 12'h800)
    else $error("first trial code wrong");
  chan_steady_a: assert property ($changed(mux_sel) |-> !hold)
    else $error("channel changed during conversion");
  span_steady_a: assert property ($changed(range_ref) |-> !hold)
    else $error("span changed during conversion");
endmodule // adc_ctl_monitor

bind adc_power_and_sequencer_control adc_ctl_monitor #(.RES_BITS(RES_BITS)) mon (.*);

// ==== bench/host_port_model.sv ====
module host_port (
  input  wire logic        ref_clk,
  input  wire logic        dout,
  input  wire logic        power_down,
  output logic             sclk = 1'b1,
  output logic             cs_b = 1'b1,
  output logic             din = 1'b0,
  output logic [15:0]      word = 16'h0000,
  output logic             got = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // One 16-clock transfer, MSB first, link clock idle high
  task automatic frame(input logic [15:0] w);
    logic [15:0] r;
    logic        pd;
    pd = power_down;
    @(posedge ref_clk) cs_b <= 1'b0;
    din <= w[15];
    repeat (pd ? 50 : 8) @(posedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      r[i] = dout;
      sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      din <= (i > 0) ? w[(i+15)%16] : ~w[0];
      repeat (4) @(posedge ref_clk);
    end
    cs_b <= 1'b1;
    word <= r;
    got <= 1'b1;
    @(posedge ref_clk) got <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // host_port

// ==== bench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, comp_in = 1'b0, err, cod = 1'b0;
  logic [11:0] paddr = 12'h000, lvl = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire         pready, pslverr, dout, dout_oe, hold, range_ref, power_down;
  wire         sclk, cs_b, din, got;
  wire  [31:0] prdata;
  wire  [11:0] dac_code;
  wire  [1:0]  mux_sel;
  wire  [15:0] word;
  logic [15:0] expq[$];
  int          fail_count = 0, n_checks = 0, cyc = 0;

  adc_power_and_sequencer_control dut (.*);
  host_port host (.*);

  initial forever #10 ref_clk = ~ref_clk;
  // Analog source: comparator trips while the level is at or above the trial
  always @(posedge ref_clk) comp_in <= (lvl >= dac_code);
  // Frame results against the oldest noted word
  always @(posedge ref_clk) if (got) chk("word", word, expq.pop_front());
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk) psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] cwf(logic [1:0] sq, logic [1:0] ch, logic [1:0] pm, logic rg);
    return {1'b1, sq[1], 2'b00, ch, pm, sq[0], 1'b0, rg, 1'b1};
  endfunction

  // Note the expected word, then run one transfer
  task automatic xfer(logic [11:0] w, logic [1:0] ch);
    lvl = 12'($urandom);
    expq.push_back({2'b00, ch, cod ? lvl : lvl ^ 12'h800});
    host.frame({w, 4'h0});
    if (w[11]) cod = w[0];
  endtask

  // Main sequence
  initial begin
    void'($urandom(27));
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg", rd, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", err, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    xfer(cwf(2'b00, 2'd2, 2'b11, 1'b1), 2'd0);
    xfer(12'h7ff, 2'd2);
    chk("span", range_ref, 32'h1);
    xfer(cwf(2'b11, 2'd2, 2'b11, 1'b0), 2'd2);
    for (int k = 0; k < 4; k++) xfer(12'h000, 2'(k % 3));
    chk("span", range_ref, 32'h0);
    xfer(cwf(2'b10, 2'd0, 2'b11, 1'b1), 2'd1);
    xfer(cwf(2'b00, 2'd3, 2'b11, 1'b1), 2'd2);
    xfer(cwf(2'b00, 2'd1, 2'b10, 1'b1), 2'd3);
    repeat (30) @(posedge ref_clk);
    chk("pd", power_down, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("ctrl", rd[10:0], 32'(cwf(2'b00, 2'd1, 2'b10, 1'b1) & 12'h7ff));
    xfer(cwf(2'b00, 2'd1, 2'b11, 1'b1), 2'd1);
    chk("pd", power_down, 32'h0);
    xfer(cwf(2'b00, 2'd1, 2'b01, 1'b1), 2'd1);
    chk("pd", power_down, 32'h1);
    xfer(cwf(2'b00, 2'd0, 2'b11, 1'b1), 2'd1);
    chk("pd", power_down, 32'h0);
    chk("queue", expq.size(), 32'h0);
    tally_and_finish();
  end
endmodule // tb
